/* File: shared/fpsi_regs.svh */
// Register offsets, field positions, reset values and timing counts of the front panel block
// Assumes inclusion by bare name from design files
`ifndef FPSI_REGS_SVH
`define FPSI_REGS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define FPSI_CTRL_OFS 8'h00
`define FPSI_STATUS_OFS 8'h04
`define FPSI_IRQ_STAT_OFS 8'h08
`define FPSI_IRQ_MASK_OFS 8'h0C
`define FPSI_MSG_OFS 8'h10
`define FPSI_LAMPS_OFS 8'h14
`define FPSI_DISP_OFS 8'h18
// ****************************************
// Control fields
// ****************************************
`define FPSI_CTRL_SELFTEST_BIT 0
`define FPSI_CTRL_RESET 32'h0000_0000
// ****************************************
// Interrupt status fields
// ****************************************
`define FPSI_IRQ_DONE_BIT 0
`define FPSI_IRQ_FAIL_BIT 1
`define FPSI_IRQ_BATT_BIT 2
`define FPSI_IRQ_NET_BIT 3
`define FPSI_IRQ_WIDTH 4
`define FPSI_IRQ_MASK_RESET 4'h0
// ****************************************
// Display geometry
// ****************************************
`define FPSI_DISP_LINES 4
`define FPSI_DISP_COLS 20
`define FPSI_CELL_DOTS_W 5
`define FPSI_CELL_DOTS_H 8
// ****************************************
// Timing
// ****************************************
`define FPSI_CLK_HZ 20000000
`define FPSI_LOOP_WAIT_US 10
`define FPSI_LOOP_WAIT_CYC ((`FPSI_CLK_HZ / 1000000) * `FPSI_LOOP_WAIT_US)
`endif

/* File: shared/fpsi_pkg.sv */
// Types of the front panel status block
// Assumes no other package
package fpsi_pkg;
  typedef enum logic [3:0] {
    FPSI_MSG_DIAG_RUN,
    FPSI_MSG_DIAG_DONE,
    FPSI_MSG_LOW_BATTERY,
    FPSI_MSG_PORT0_BAD,
    FPSI_MSG_PORT1_BAD,
    FPSI_MSG_PORT2_BAD,
    FPSI_MSG_PORT3_BAD,
    FPSI_MSG_NO_NET,
    FPSI_MSG_READY
  } fpsi_msg_t;
  typedef enum logic [2:0] {
    FPSI_ST_IDLE,
    FPSI_ST_DRIVE,
    FPSI_ST_WAIT,
    FPSI_ST_CHECK,
    FPSI_ST_DONE
  } fpsi_state_t;
endpackage

/* File: design/fpsi_sync.sv */
// Two flip-flop synchroniser bank for asynchronous inputs
// Assumes one clock and an active low asynchronous reset
`timescale 1ns/1ns
module fpsi_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_nxt;
  initial begin
    if (WIDTH < 1) begin
      $error("fpsi_sync width must be at least one");
    end
  end
  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_out <= sync_nxt;
    end
  end
endmodule

/* File: design/fpsi_top.sv */
// Front panel status lamps, power-up port self-test and status message select
// Assumes pin inputs are asynchronous, AXI4-Lite master on clk
`timescale 1ns/1ns
`include "fpsi_regs.svh"
module fpsi_top #(
  parameter int PORTS = 4,
  parameter int LOOP_WAIT = `FPSI_LOOP_WAIT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Processor and battery pins
  input wire logic cpu_running,
  input wire logic battery_low,
  // Serial port activity and loopback return pins
  input wire logic [PORTS-1:0] port_rx_active,
  input wire logic [PORTS-1:0] port_tx_active,
  input wire logic [PORTS-1:0] port_irq,
  input wire logic [PORTS-1:0] port_loop_rx,
  // Local bus and network pins
  input wire logic local_tx_active,
  input wire logic local_rx_active,
  input wire logic net_traffic,
  input wire logic net_member,
  // Loopback drive and lamps
  output logic [PORTS-1:0] port_loop_tx,
  output logic processor_lamp,
  output logic fault_lamp,
  output logic [PORTS-1:0] receive_lamp,
  output logic [PORTS-1:0] transmit_lamp,
  output logic [PORTS-1:0] interrupt_lamp,
  output logic local_tx_lamp,
  output logic local_rx_lamp,
  output logic token_network_activity_lamp,
  // Display message and interrupt
  output logic [3:0] status_msg,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int NIN = 3 * PORTS + 6 + PORTS;
  initial begin
    if (PORTS < 1 || PORTS > 4) begin
      $error("fpsi_top serves one to four serial ports");
    end
    // The echo needs three edges to come back through the pin synchroniser
    if (LOOP_WAIT < 2 || LOOP_WAIT > 65536) begin
      $error("fpsi_top loopback wait must cover the echo path and fit the counter");
    end
  end
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [NIN-1:0] pins_s;
  logic cpu_s, batt_s, ltx_s, lrx_s, ntr_s, nmb_s;
  logic [PORTS-1:0] rx_s, tx_s, irq_s, lrt_s;
  fpsi_sync #(.WIDTH(NIN)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in({port_loop_rx, port_irq, port_tx_active, port_rx_active,
               net_member, net_traffic, local_rx_active, local_tx_active, battery_low, cpu_running}),
    .sync_out(pins_s)
  );
  assign {lrt_s, irq_s, tx_s, rx_s, nmb_s, ntr_s, lrx_s, ltx_s, batt_s, cpu_s} = pins_s;
  // ****************************************
  // Lamps
  // ****************************************
  logic processor_lamp_nxt, fault_lamp_nxt, local_tx_lamp_nxt, local_rx_lamp_nxt, net_lamp_nxt;
  logic [PORTS-1:0] receive_lamp_nxt, transmit_lamp_nxt, interrupt_lamp_nxt;
  always_comb begin
    processor_lamp_nxt = cpu_s;
    fault_lamp_nxt = batt_s;
    receive_lamp_nxt = rx_s;
    transmit_lamp_nxt = tx_s;
    interrupt_lamp_nxt = irq_s;
    local_tx_lamp_nxt = ltx_s;
    local_rx_lamp_nxt = lrx_s;
    net_lamp_nxt = ntr_s & nmb_s;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      processor_lamp <= 1'b0;
      fault_lamp <= 1'b0;
      receive_lamp <= '0;
      transmit_lamp <= '0;
      interrupt_lamp <= '0;
      local_tx_lamp <= 1'b0;
      local_rx_lamp <= 1'b0;
      token_network_activity_lamp <= 1'b0;
    end else begin
      processor_lamp <= processor_lamp_nxt;
      fault_lamp <= fault_lamp_nxt;
      receive_lamp <= receive_lamp_nxt;
      transmit_lamp <= transmit_lamp_nxt;
      interrupt_lamp <= interrupt_lamp_nxt;
      local_tx_lamp <= local_tx_lamp_nxt;
      local_rx_lamp <= local_rx_lamp_nxt;
      token_network_activity_lamp <= net_lamp_nxt;
    end
  end
  // ****************************************
  // Loopback self-test
  // ****************************************
  // Each port is driven high then low; the echo must follow both levels
  fpsi_pkg::fpsi_state_t st_r, st_nxt;
  logic [1:0] port_r, port_nxt;
  logic phase_r, phase_nxt;
  logic [PORTS-1:0] fail_r, fail_nxt, loop_tx_nxt;
  logic [15:0] wait_r, wait_nxt;
  logic done_r, done_nxt, start_req;
  fpsi_pkg::fpsi_msg_t msg_nxt;
  always_comb begin
    st_nxt = st_r;
    port_nxt = port_r;
    phase_nxt = phase_r;
    fail_nxt = fail_r;
    wait_nxt = wait_r;
    done_nxt = done_r;
    loop_tx_nxt = '0;
    unique case (st_r)
      fpsi_pkg::FPSI_ST_IDLE: begin
        if (start_req) begin
          st_nxt = fpsi_pkg::FPSI_ST_DRIVE;
          port_nxt = 2'h0;
          phase_nxt = 1'b1;
          fail_nxt = '0;
          done_nxt = 1'b0;
        end
      end
      fpsi_pkg::FPSI_ST_DRIVE: begin
        wait_nxt = 16'(LOOP_WAIT - 1);
        st_nxt = fpsi_pkg::FPSI_ST_WAIT;
      end
      fpsi_pkg::FPSI_ST_WAIT: begin
        if (wait_r == 16'h0000) begin
          st_nxt = fpsi_pkg::FPSI_ST_CHECK;
        end else begin
          wait_nxt = wait_r - 16'h0001;
        end
      end
      fpsi_pkg::FPSI_ST_CHECK: begin
        if (lrt_s[port_r] != phase_r) begin
          fail_nxt[port_r] = 1'b1;
        end
        if (phase_r) begin
          phase_nxt = 1'b0;
          st_nxt = fpsi_pkg::FPSI_ST_DRIVE;
        end else if (32'(port_r) == PORTS - 1) begin
          st_nxt = fpsi_pkg::FPSI_ST_DONE;
        end else begin
          port_nxt = port_r + 2'h1;
          phase_nxt = 1'b1;
          st_nxt = fpsi_pkg::FPSI_ST_DRIVE;
        end
      end
      fpsi_pkg::FPSI_ST_DONE: begin
        done_nxt = 1'b1;
        st_nxt = fpsi_pkg::FPSI_ST_IDLE;
      end
    endcase
    if (st_r == fpsi_pkg::FPSI_ST_DRIVE || st_r == fpsi_pkg::FPSI_ST_WAIT || st_r == fpsi_pkg::FPSI_ST_CHECK) begin
      loop_tx_nxt[port_r] = phase_r;
    end
  end
  // ****************************************
  // Status message select
  // ****************************************
  always_comb begin
    msg_nxt = fpsi_pkg::FPSI_MSG_DIAG_RUN;
    if (done_r) begin
      if (batt_s) begin
        msg_nxt = fpsi_pkg::FPSI_MSG_LOW_BATTERY;
      end else if (fail_r != '0) begin
        // Lowest failing port wins; all failures stay visible in the status register
        for (int i = PORTS - 1; i >= 0; i--) begin
          if (fail_r[i]) begin
            msg_nxt = fpsi_pkg::fpsi_msg_t'(4'(int'(fpsi_pkg::FPSI_MSG_PORT0_BAD) + i));
          end
        end
      end else if (ntr_s & nmb_s) begin
        msg_nxt = fpsi_pkg::FPSI_MSG_READY;
      end else begin
        msg_nxt = fpsi_pkg::FPSI_MSG_NO_NET;
      end
    end else if (st_r == fpsi_pkg::FPSI_ST_DONE) begin
      msg_nxt = fpsi_pkg::FPSI_MSG_DIAG_DONE;
    end
  end
  // ****************************************
  // Register file and interrupts
  // ****************************************
  logic boot_r, start_sw;
  logic [`FPSI_IRQ_WIDTH-1:0] ist_r, ist_nxt, imask_r, imask_nxt, ev;
  logic batt_d_r, net_d_r, ack_w, do_wr, wlane_r, wlane_nxt;
  logic aw_held_r, w_held_r, aw_held_nxt, w_held_nxt, bvalid_nxt, rvalid_nxt, irq_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_nxt;
  logic [1:0] bresp_nxt, rresp_nxt;
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= `FPSI_DISP_OFS) && (a[1:0] == 2'b00);
  endfunction
  assign start_req = boot_r | start_sw;
  assign do_wr = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign ack_w = do_wr & (awaddr_r == `FPSI_IRQ_STAT_OFS) & wlane_r;
  assign start_sw = do_wr & (awaddr_r == `FPSI_CTRL_OFS) & wdata_r[`FPSI_CTRL_SELFTEST_BIT] & wlane_r;
  always_comb begin
    ev = '0;
    ev[`FPSI_IRQ_DONE_BIT] = (st_r == fpsi_pkg::FPSI_ST_DONE);
    ev[`FPSI_IRQ_FAIL_BIT] = (st_r == fpsi_pkg::FPSI_ST_DONE) && (fail_r != '0);
    ev[`FPSI_IRQ_BATT_BIT] = batt_s & ~batt_d_r;
    ev[`FPSI_IRQ_NET_BIT] = (ntr_s & nmb_s) != net_d_r;
    // Set beats clear when both land together
    ist_nxt = (ist_r & ~(ack_w ? wdata_r[`FPSI_IRQ_WIDTH-1:0] : '0)) | ev;
    imask_nxt = imask_r;
    if (do_wr && awaddr_r == `FPSI_IRQ_MASK_OFS && wlane_r) begin
      imask_nxt = wdata_r[`FPSI_IRQ_WIDTH-1:0];
    end
    irq_nxt = (ist_nxt & imask_nxt) != '0;
    aw_held_nxt = (aw_held_r | s_axi_awvalid) & ~do_wr;
    w_held_nxt = (w_held_r | s_axi_wvalid) & ~do_wr;
    awaddr_nxt = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awaddr_r;
    wdata_nxt = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wdata_r;
    // Lane kept with the data; the master may move the strobe once W is taken
    wlane_nxt = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb[0] : wlane_r;
    bvalid_nxt = do_wr | (s_axi_bvalid & ~s_axi_bready);
    bresp_nxt = do_wr ? (mapped(awaddr_r) ? 2'h0 : 2'h2) : s_axi_bresp;
    rvalid_nxt = (s_axi_arvalid & s_axi_arready) | (s_axi_rvalid & ~s_axi_rready);
    rresp_nxt = s_axi_rresp;
    rdata_nxt = s_axi_rdata;
    if (s_axi_arvalid & s_axi_arready) begin
      rresp_nxt = mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      unique case (s_axi_araddr)
        `FPSI_STATUS_OFS: rdata_nxt = {24'h0, 4'(fail_r), 1'b0, st_r == fpsi_pkg::FPSI_ST_IDLE, done_r, net_lamp_nxt};
        `FPSI_IRQ_STAT_OFS: rdata_nxt = {28'h0, ist_r};
        `FPSI_IRQ_MASK_OFS: rdata_nxt = {28'h0, imask_r};
        `FPSI_MSG_OFS: rdata_nxt = {28'h0, status_msg};
        `FPSI_LAMPS_OFS: rdata_nxt = {15'h0, token_network_activity_lamp, local_rx_lamp, local_tx_lamp,
                                      fault_lamp, processor_lamp, 4'(interrupt_lamp), 4'(transmit_lamp), 4'(receive_lamp)};
        `FPSI_DISP_OFS: rdata_nxt = {8'(`FPSI_CELL_DOTS_H), 8'(`FPSI_CELL_DOTS_W), 8'(`FPSI_DISP_COLS), 8'(`FPSI_DISP_LINES)};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= fpsi_pkg::FPSI_ST_IDLE;
      port_r <= 2'h0;
      phase_r <= 1'b0;
      fail_r <= '0;
      wait_r <= 16'h0000;
      done_r <= 1'b0;
      boot_r <= 1'b1;
      port_loop_tx <= '0;
      status_msg <= 4'h0;
      ist_r <= '0;
      imask_r <= `FPSI_IRQ_MASK_RESET;
      batt_d_r <= 1'b0;
      net_d_r <= 1'b0;
      irq <= 1'b0;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wlane_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_arready <= 1'b1;
    end else begin
      st_r <= st_nxt;
      port_r <= port_nxt;
      phase_r <= phase_nxt;
      fail_r <= fail_nxt;
      wait_r <= wait_nxt;
      done_r <= done_nxt;
      boot_r <= 1'b0;
      port_loop_tx <= loop_tx_nxt;
      status_msg <= 4'(msg_nxt);
      ist_r <= ist_nxt;
      imask_r <= imask_nxt;
      batt_d_r <= batt_s;
      net_d_r <= ntr_s & nmb_s;
      irq <= irq_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wlane_r <= wlane_nxt;
      s_axi_bvalid <= bvalid_nxt;
      s_axi_bresp <= bresp_nxt;
      s_axi_rvalid <= rvalid_nxt;
      s_axi_rresp <= rresp_nxt;
      s_axi_rdata <= rdata_nxt;
      // Ready held low while a word waits, so a second one cannot overwrite it
      s_axi_awready <= ~aw_held_nxt;
      s_axi_wready <= ~w_held_nxt;
      s_axi_arready <= ~rvalid_nxt;
    end
  end
endmodule

/* File: bench/fpsi_loop_model.sv */
// Serial loopback far side of the power-up port test
// Assumes the bench sets brk to break chosen ports
`timescale 1ns/1ns
module fpsi_loop_model #(
  parameter int PORTS = 4
) (
  // Pins
  input wire logic [PORTS-1:0] port_loop_tx,
  input wire logic [PORTS-1:0] brk,
  output logic [PORTS-1:0] port_loop_rx
);
  // Broken port echoes the inverse, so it never matches by luck
  assign port_loop_rx = port_loop_tx ^ brk;
endmodule

/* File: bench/fpsi_top_props.sv */
// Checker of the lamp and message outputs of the front panel block
// Assumes lamps trail their pins by three edges
`timescale 1ns/1ns
module fpsi_top_props #(
  parameter int PORTS = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Pins
  input wire logic cpu_running,
  input wire logic battery_low,
  input wire logic [PORTS-1:0] port_rx_active,
  input wire logic [PORTS-1:0] port_tx_active,
  input wire logic [PORTS-1:0] port_irq,
  input wire logic local_tx_active,
  input wire logic local_rx_active,
  input wire logic net_traffic,
  input wire logic net_member,
  // Lamps and message
  input wire logic processor_lamp,
  input wire logic fault_lamp,
  input wire logic [PORTS-1:0] receive_lamp,
  input wire logic [PORTS-1:0] transmit_lamp,
  input wire logic [PORTS-1:0] interrupt_lamp,
  input wire logic local_tx_lamp,
  input wire logic local_rx_lamp,
  input wire logic token_network_activity_lamp,
  input wire logic [3:0] status_msg
);
  // ****************************************
  // Edges since reset
  // ****************************************
  // Past values from inside reset are not compared
  logic [1:0] up_r;
  logic [1:0] up_nxt;
  always_comb begin
    up_nxt = (up_r == 2'h3) ? up_r : up_r + 2'h1;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      up_r <= 2'h0;
    end else begin
      up_r <= up_nxt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ****************************************
  // Properties
  // ****************************************
  property p_cpu; up_r == 2'h3 |-> processor_lamp == $past(cpu_running, 3); endproperty
  a_cpu: assert property (p_cpu) else $error("processor lamp wrong");
  property p_fault; up_r == 2'h3 |-> fault_lamp == $past(battery_low, 3); endproperty
  a_fault: assert property (p_fault) else $error("fault lamp wrong");
  property p_rx; up_r == 2'h3 |-> receive_lamp == $past(port_rx_active, 3); endproperty
  a_rx: assert property (p_rx) else $error("receive lamp wrong");
  property p_tx; up_r == 2'h3 |-> transmit_lamp == $past(port_tx_active, 3); endproperty
  a_tx: assert property (p_tx) else $error("transmit lamp wrong");
  property p_irq; up_r == 2'h3 |-> interrupt_lamp == $past(port_irq, 3); endproperty
  a_irq: assert property (p_irq) else $error("interrupt lamp wrong");
  property p_ltx; up_r == 2'h3 |-> local_tx_lamp == $past(local_tx_active, 3); endproperty
  a_ltx: assert property (p_ltx) else $error("local transmit lamp wrong");
  property p_lrx; up_r == 2'h3 |-> local_rx_lamp == $past(local_rx_active, 3); endproperty
  a_lrx: assert property (p_lrx) else $error("local receive lamp wrong");
  property p_net;
    up_r == 2'h3 |-> token_network_activity_lamp == $past(net_traffic && net_member, 3);
  endproperty
  a_net: assert property (p_net) else $error("network lamp wrong");
  property p_rst;
    $rose(arst_n) |-> !processor_lamp && !fault_lamp && receive_lamp == '0 && transmit_lamp == '0 &&
      interrupt_lamp == '0 && !local_tx_lamp && !local_rx_lamp && !token_network_activity_lamp;
  endproperty
  a_rst: assert property (p_rst) else $error("lamp lit out of reset");
  property p_msg; status_msg <= 4'h8; endproperty
  a_msg: assert property (p_msg) else $error("message code out of range");
endmodule
bind fpsi_top fpsi_top_props #(.PORTS(PORTS)) fpsi_top_props_i (
  .clk(clk), .arst_n(arst_n), .cpu_running(cpu_running), .battery_low(battery_low),
  .port_rx_active(port_rx_active), .port_tx_active(port_tx_active), .port_irq(port_irq),
  .local_tx_active(local_tx_active), .local_rx_active(local_rx_active), .net_traffic(net_traffic),
  .net_member(net_member), .processor_lamp(processor_lamp), .fault_lamp(fault_lamp),
  .receive_lamp(receive_lamp), .transmit_lamp(transmit_lamp), .interrupt_lamp(interrupt_lamp),
  .local_tx_lamp(local_tx_lamp), .local_rx_lamp(local_rx_lamp),
  .token_network_activity_lamp(token_network_activity_lamp), .status_msg(status_msg)
);

/* File: bench/tb_fpsi_top.sv */
// Self-checking bench of the front panel block
// Assumes loopback model on the test pins, AXI4-Lite master here
`timescale 1ns/1ns
`include "fpsi_regs.svh"
module tb_fpsi_top;
  localparam int P = 4;
  logic clk, arst_n, cpu_running, battery_low, local_tx_active, local_rx_active, net_traffic, net_member;
  logic [P-1:0] port_rx_active, port_tx_active, port_irq, port_loop_rx, port_loop_tx, brk;
  logic [P-1:0] receive_lamp, transmit_lamp, interrupt_lamp;
  logic processor_lamp, fault_lamp, local_tx_lamp, local_rx_lamp, token_network_activity_lamp, irq;
  logic [3:0] status_msg, s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, rb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_mismatch, check_count, cyc;
  // Short loop wait keeps each self-test near fifty cycles
  fpsi_top #(.PORTS(P), .LOOP_WAIT(4)) fpsi_top_i (
    .clk(clk), .arst_n(arst_n), .cpu_running(cpu_running), .battery_low(battery_low),
    .port_rx_active(port_rx_active), .port_tx_active(port_tx_active), .port_irq(port_irq),
    .port_loop_rx(port_loop_rx), .local_tx_active(local_tx_active), .local_rx_active(local_rx_active),
    .net_traffic(net_traffic), .net_member(net_member), .port_loop_tx(port_loop_tx),
    .processor_lamp(processor_lamp), .fault_lamp(fault_lamp), .receive_lamp(receive_lamp),
    .transmit_lamp(transmit_lamp), .interrupt_lamp(interrupt_lamp), .local_tx_lamp(local_tx_lamp),
    .local_rx_lamp(local_rx_lamp), .token_network_activity_lamp(token_network_activity_lamp),
    .status_msg(status_msg), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );
  fpsi_loop_model #(.PORTS(P)) fpsi_loop_model_i (.port_loop_tx(port_loop_tx), .brk(brk),
    .port_loop_rx(port_loop_rx));
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Handshakes sampled at the rising edge; each channel dropped at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic b;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      b = s_axi_bvalid;
      rb = s_axi_bresp;
    end while (b !== 1'h1);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic r;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      r = s_axi_rvalid;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
    end while (r !== 1'h1);
    s_axi_rready <= 1'h0;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      rd(`FPSI_STATUS_OFS);
      n++;
    end while (rv[1] !== 1'h1 && n < 100);
    chk(32'(rv[1]), 32'h1);
  endtask
  // Vector {cpu, battery, rx, tx, irq, local tx, local rx, traffic, member}
  task automatic lamp_case(input logic [17:0] v);
    @(posedge clk);
    {cpu_running, battery_low, port_rx_active, port_tx_active, port_irq, local_tx_active, local_rx_active,
      net_traffic, net_member} <= v;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk(32'(processor_lamp), 32'(v[17]));
    chk(32'(fault_lamp), 32'(v[16]));
    chk(32'(receive_lamp), 32'(v[15:12]));
    chk(32'(transmit_lamp), 32'(v[11:8]));
    chk(32'(interrupt_lamp), 32'(v[7:4]));
    chk(32'(local_tx_lamp), 32'(v[3]));
    chk(32'(local_rx_lamp), 32'(v[2]));
    chk(32'(token_network_activity_lamp), 32'(v[1] & v[0]));
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    repeat (6) @(posedge clk);
    chk(32'(processor_lamp), 32'h0);
    arst_n <= 1'h1;
    rd(`FPSI_DISP_OFS);
    chk(rv, 32'h0805_1404);
    chk(32'(status_msg), 32'h0);
    rd(`FPSI_IRQ_MASK_OFS);
    chk(rv, 32'h0);
    // Power-up test must finish before battery and network messages can show
    wait_done();
    chk(32'(status_msg), 32'h7);
    $display("test reset done");
  endtask
  task automatic t_lamps();
    lamp_case(18'h25A3A);
    lamp_case(18'h1A5C7);
    repeat (4) @(posedge clk);
    chk(32'(status_msg), 32'h2);
    lamp_case(18'h00001);
    $display("test lamps done");
  endtask
  task automatic t_ready();
    lamp_case(18'h00003);
    wr(`FPSI_CTRL_OFS, 32'h1);
    chk(32'(rb), 32'h0);
    wait_done();
    chk(32'(status_msg), 32'h8);
    rd(`FPSI_MSG_OFS);
    chk(rv, 32'h8);
    lamp_case(18'h00002);
    repeat (4) @(posedge clk);
    chk(32'(status_msg), 32'h7);
    rd(8'h40);
    chk(32'(rr), 32'h2);
    chk(rv, 32'h0);
    wr(8'h40, 32'h0);
    chk(32'(rb), 32'h2);
    $display("test ready done");
  endtask
  // Each port broken alone, the fail interrupt raised then cleared
  task automatic t_fail();
    lamp_case(18'h00000);
    wr(`FPSI_IRQ_MASK_OFS, 32'h2);
    for (int p = 0; p < P; p++) begin
      brk <= 4'(1 << p);
      wr(`FPSI_CTRL_OFS, 32'h1);
      wait_done();
      chk(32'(status_msg), 32'(3 + p));
      rd(`FPSI_STATUS_OFS);
      chk(32'(rv[7:4]), 32'(1 << p));
      chk(32'(irq), 32'h1);
      wr(`FPSI_IRQ_STAT_OFS, 32'hF);
      repeat (3) @(posedge clk);
      chk(32'(irq), 32'h0);
    end
    brk <= 4'h0;
    $display("test fail done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    {arst_n, battery_low, local_tx_active, local_rx_active, net_traffic, net_member} = 6'h0;
    cpu_running = 1'h1;
    {port_rx_active, port_tx_active, port_irq, brk} = 16'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    t_reset();
    t_lamps();
    t_ready();
    t_fail();
    finish_test();
  end
endmodule
